/* include/plg_cfg.svh */
/*
 * Constants of the protection latch logic: register offsets, field
 * positions, reset values and timing counts.
 * Assumes a 250 MHz core clock and a 32-bit classic Wishbone bus.
 */
`ifndef PLG_CFG_SVH
`define PLG_CFG_SVH

// ***************************************************************
// clock
// ***************************************************************
`define PLG_CLK_MHZ        250

// ***************************************************************
// timing: time in its own unit, then the derived cycle count
// ***************************************************************
`define PLG_TRAN_MS        3600
`define PLG_TRAN_CYC       (`PLG_TRAN_MS * `PLG_CLK_MHZ * 1000)
`define PLG_FAULT_MS       100
`define PLG_FAULT_CYC      (`PLG_FAULT_MS * `PLG_CLK_MHZ * 1000)
`define PLG_HI_BLANK_US    50
`define PLG_HI_BLANK_CYC   (`PLG_HI_BLANK_US * `PLG_CLK_MHZ)
`define PLG_LO_BLANK_US    350
`define PLG_LO_BLANK_CYC   (`PLG_LO_BLANK_US * `PLG_CLK_MHZ)
`define PLG_SS_MS          5
`define PLG_SS_CYC         (`PLG_SS_MS * `PLG_CLK_MHZ * 1000)
`define PLG_AREC_MS        1000
`define PLG_AREC_CYC       (`PLG_AREC_MS * `PLG_CLK_MHZ * 1000)

// ***************************************************************
// register byte offsets
// ***************************************************************
`define PLG_CTRL_OFS       8'h00
`define PLG_STAT_OFS       8'h04
`define PLG_IRQ_OFS        8'h08
`define PLG_MASK_OFS       8'h0C

// ***************************************************************
// fields and reset values
// ***************************************************************
`define PLG_CTRL_AREC_BIT  0
`define PLG_CTRL_RST       1'h0
`define PLG_EVT_RST        5'h0_0
`define PLG_MASK_RST       5'h0_0

`endif

/* include/plg_pkg.sv */
/*
 * Types of the protection latch logic: sequencer states and the
 * packed groups of comparator inputs and interrupt events.
 * Assumes plg_cfg.svh for all numeric constants.
 */
package plg_pkg;

	// ***************************************************************
	// sequencer states
	// ***************************************************************
	typedef enum logic [2:0] {
		S_WAIT  = 3'b000,
		S_SOFT  = 3'b001,
		S_RUN   = 3'b010,
		S_PROT  = 3'b011,
		S_AREC  = 3'b100,
		S_THERM = 3'b101
	} plg_state_t;

	// ***************************************************************
	// comparator and supply monitor results, all asynchronous
	// ***************************************************************
	typedef struct packed {
		logic cs_above_tran;
		logic cs_above_limit;
		logic latch_high;
		logic latch_low;
		logic thermal_shutdown;
		logic supply_start_level;
		logic supply_reset;
		logic brown_out;
	} plg_sense_t;

	// ***************************************************************
	// sticky interrupt events, same layout for status and mask
	// ***************************************************************
	typedef struct packed {
		logic thermal;
		logic latch_low;
		logic latch_high;
		logic fault_to;
		logic tran_to;
	} plg_evt_t;

endpackage : plg_pkg

/* rtl/plg_hold.sv */
/*
 * Hold counter: done rises once the input has stayed high for LEN
 * consecutive enabled cycles; any drop or disable restarts it.
 * Assumes inputs already synchronised to the core clock.
 */
`timescale 1ns/1ps

module plg_hold #(
	parameter logic [31:0] LEN = 32'h0000_0001
) (
	input  wire logic CORE_CLK,
	input  wire logic RST_N,
	input  wire logic EN,
	input  wire logic LVL,
	output wire logic DONE
);

	logic [31:0] cnt_ff;

	// saturating count, so done stays until the level drops
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N || !EN || !LVL) begin
			cnt_ff <= 32'h0000_0000;
		end else if (cnt_ff != LEN) begin
			cnt_ff <= cnt_ff + 32'h0000_0001;
		end
	end

	assign DONE = (cnt_ff == LEN);

endmodule : plg_hold

/* rtl/plg_core.sv */
/*
 * Protection sequencer of a flyback current-mode controller:
 * transient and overload timers, latch-off window with blanking,
 * start-up gating, soft-start bias select and thermal shutdown,
 * plus a classic Wishbone register slave with a level interrupt.
 * Assumes comparator inputs are asynchronous and that the analog
 * side honours the bias select and supply hold outputs.
 */
`timescale 1ns/1ps
`include "plg_cfg.svh"

// Functional notes
// R1: count transient timer while current sense exceeds transient threshold.
// R2: transient timer expiry enters protection, latched or autorecovery by option.
// R3: overload timer also counts when load moves into overload.
// R4: switch only inside latch window; latch off when either threshold crossed.
// R5: blank high latch 50 us and low latch 350 us.
// R6: latched-off state cleared only by brown-out or supply reset; the code also leaves it via thermal shutdown.
// R7: ignore latch comparators until controller is ready to start.
// R8: at start level, check high latch; switch only if allowed.
// R9: evaluate low latch only after soft-start ends.
// R10: doubled thermistor bias during soft-start, normal bias afterwards.
// R11: thermal shutdown stops switching at once and enters low-power off.
// R12: keep supply present during thermal shutdown.
// R13: after cooling, re-enable start-up with a normal sequence.
// R14: clear overload timer when sense drops below current limit.
// R15: clear transient timer when sense drops below transient threshold.
module plg_core #(
	parameter logic [31:0] TRAN_CYC  = `PLG_TRAN_CYC,
	parameter logic [31:0] FAULT_CYC = `PLG_FAULT_CYC,
	parameter logic [31:0] HI_CYC    = `PLG_HI_BLANK_CYC,
	parameter logic [31:0] LO_CYC    = `PLG_LO_BLANK_CYC,
	parameter logic [31:0] SS_CYC    = `PLG_SS_CYC,
	parameter logic [31:0] AREC_CYC  = `PLG_AREC_CYC
) (
	input  wire logic               CORE_CLK,
	input  wire logic               RST_N,
	input  wire plg_pkg::plg_sense_t SENSE,
	input  wire logic               WB_CYC_I,
	input  wire logic               WB_STB_I,
	input  wire logic               WB_WE_I,
	input  wire logic [7:0]         WB_ADR_I,
	input  wire logic [3:0]         WB_SEL_I,
	input  wire logic [31:0]        WB_DAT_I,
	output wire logic [31:0]        WB_DAT_O,
	output wire logic               WB_ACK_O,
	output wire logic               GATE_DRIVE_EN,
	output wire logic               SOFTSTART_BIAS_SEL,
	output wire logic               SUPPLY_HOLD,
	output wire logic               LOW_POWER_OFF,
	output wire logic               IRQ
);
	import plg_pkg::*;

	// ***************************************************************
	// input synchronisers
	// ***************************************************************
	plg_sense_t meta_ff;
	plg_sense_t sync_ff;

	// two stages on every comparator; only the second one is read
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= SENSE;
			sync_ff <= meta_ff;
		end
	end

	wire logic tran_s  = sync_ff.cs_above_tran;
	wire logic lim_s   = sync_ff.cs_above_limit;
	wire logic hi_s    = sync_ff.latch_high;
	wire logic lo_s    = sync_ff.latch_low;
	wire logic therm_s = sync_ff.thermal_shutdown;
	wire logic start_s = sync_ff.supply_start_level;
	wire logic rel_s   = sync_ff.supply_reset | sync_ff.brown_out;

	// ***************************************************************
	// state and timers
	// ***************************************************************
	plg_state_t state_ff;
	plg_state_t nxt_state;
	logic       drive_ff;
	logic       bias_ff;
	logic       hold_ff;
	logic       arec_en_ff;

	wire logic switching = (state_ff == S_SOFT) || (state_ff == S_RUN);
	// references settle before start level, so nothing earlier counts
	wire logic ready     = (state_ff != S_WAIT) || start_s;       // R7
	wire logic hi_en     = ready && (state_ff != S_THERM);        // R7
	wire logic lo_en     = (state_ff == S_RUN);                   // R9
	wire logic tran_done;
	wire logic flt_done;
	wire logic hi_done;
	wire logic lo_done;
	wire logic ss_done;
	wire logic arec_done;

	// transient timer, restarted when sense falls below threshold
	plg_hold #(.LEN(TRAN_CYC)) u_tran (                           // R1 R15
		.CORE_CLK (CORE_CLK),
		.RST_N    (RST_N),
		.EN       (switching),
		.LVL      (tran_s),
		.DONE     (tran_done)
	);

	// overload timer runs alongside the transient one
	plg_hold #(.LEN(FAULT_CYC)) u_fault (                         // R3 R14
		.CORE_CLK (CORE_CLK),
		.RST_N    (RST_N),
		.EN       (switching),
		.LVL      (lim_s),
		.DONE     (flt_done)
	);

	// high latch blanking, spikes shorter than the window vanish
	plg_hold #(.LEN(HI_CYC)) u_hi (                               // R5
		.CORE_CLK (CORE_CLK),
		.RST_N    (RST_N),
		.EN       (hi_en),
		.LVL      (hi_s),
		.DONE     (hi_done)
	);

	// low latch blanking, longer since the thermistor input is slow
	plg_hold #(.LEN(LO_CYC)) u_lo (                               // R5
		.CORE_CLK (CORE_CLK),
		.RST_N    (RST_N),
		.EN       (lo_en),
		.LVL      (lo_s),
		.DONE     (lo_done)
	);

	// soft-start duration
	plg_hold #(.LEN(SS_CYC)) u_ss (
		.CORE_CLK (CORE_CLK),
		.RST_N    (RST_N),
		.EN       (state_ff == S_SOFT),
		.LVL      (1'b1),
		.DONE     (ss_done)
	);

	// autorecovery pause before the next start attempt
	plg_hold #(.LEN(AREC_CYC)) u_arec (
		.CORE_CLK (CORE_CLK),
		.RST_N    (RST_N),
		.EN       (state_ff == S_AREC),
		.LVL      (1'b1),
		.DONE     (arec_done)
	);

	// ***************************************************************
	// sequencer
	// ***************************************************************
	wire logic latch_trip = hi_done || lo_done;                   // R4
	wire logic timer_trip = tran_done || flt_done;                // R2
	wire plg_state_t trip_dst = arec_en_ff ? S_AREC : S_PROT;     // R2

	// thermal first, then release, then the per-state moves
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			S_WAIT: begin
				if (start_s && hi_done) begin
					nxt_state = S_PROT;                           // R8
				end else if (start_s && !hi_s) begin
					nxt_state = S_SOFT;                           // R8
				end
			end
			S_SOFT, S_RUN: begin
				if (latch_trip) begin
					nxt_state = S_PROT;                           // R4
				end else if (timer_trip) begin
					nxt_state = trip_dst;                         // R2
				end else if (state_ff == S_SOFT && ss_done) begin
					nxt_state = S_RUN;
				end
			end
			S_PROT: begin
				nxt_state = S_PROT;
			end
			S_AREC: begin
				if (arec_done) begin
					nxt_state = S_WAIT;
				end
			end
			S_THERM: begin
				if (!therm_s) begin
					nxt_state = S_WAIT;                           // R13
				end
			end
			default: begin
				nxt_state = S_WAIT;
			end
		endcase
		if (rel_s && state_ff != S_THERM) begin
			nxt_state = S_WAIT;                                   // R6
		end
		if (therm_s) begin
			nxt_state = S_THERM;                                  // R11
		end
	end

	wire logic nxt_drive = (nxt_state == S_SOFT) || (nxt_state == S_RUN);
	wire logic nxt_bias  = (nxt_state == S_SOFT);                 // R10
	wire logic nxt_hold  = (nxt_state == S_THERM);                // R12

	// outputs registered from the next state to avoid glitches
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			state_ff <= S_WAIT;
			drive_ff <= 1'b0;
			bias_ff  <= 1'b0;
			hold_ff  <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			drive_ff <= nxt_drive;
			bias_ff  <= nxt_bias;
			hold_ff  <= nxt_hold;
		end
	end

	// hot die cuts the driver in the same cycle, not one later
	assign GATE_DRIVE_EN      = drive_ff & ~therm_s;              // R11
	assign SOFTSTART_BIAS_SEL = bias_ff;                          // R10
	assign SUPPLY_HOLD        = hold_ff;                          // R12
	assign LOW_POWER_OFF      = hold_ff;                          // R11

	// ***************************************************************
	// interrupt events
	// ***************************************************************
	plg_evt_t evt_ff;
	plg_evt_t mask_ff;
	plg_evt_t evt_set;
	plg_evt_t evt_clr;

	assign evt_set = {therm_s && (state_ff != S_THERM), lo_done, hi_done,
	                  switching && flt_done, switching && tran_done};
	assign IRQ                = |(evt_ff & mask_ff);

	// ***************************************************************
	// wishbone slave
	// ***************************************************************
	logic        ack_ff;
	logic [31:0] dat_ff;

	wire logic req      = WB_CYC_I && WB_STB_I;
	wire logic wr_now   = req && WB_WE_I && ack_ff && WB_SEL_I[0];
	wire logic sel_ctrl = (WB_ADR_I == `PLG_CTRL_OFS);
	wire logic sel_stat = (WB_ADR_I == `PLG_STAT_OFS);
	wire logic sel_irq  = (WB_ADR_I == `PLG_IRQ_OFS);
	wire logic sel_mask = (WB_ADR_I == `PLG_MASK_OFS);

	// unmapped addresses still ack, reading zero
	wire logic [31:0] rd_mux =
		sel_ctrl ? {31'h0000_0000, arec_en_ff} :
		sel_stat ? {24'h00_0000, drive_ff, bias_ff, hold_ff,
		            tran_done, flt_done, state_ff} :
		sel_irq  ? {27'h000_0000, evt_ff} :
		sel_mask ? {27'h000_0000, mask_ff} : 32'h0000_0000;

	assign evt_clr  = (wr_now && sel_irq) ? WB_DAT_I[4:0] : 5'h0_0;
	assign WB_ACK_O = ack_ff;
	assign WB_DAT_O = dat_ff;

	// one wait state; the write lands on the edge that sees ack
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			ack_ff <= 1'b0;
			dat_ff <= 32'h0000_0000;
		end else begin
			ack_ff <= req && !ack_ff;
			dat_ff <= (req && !ack_ff) ? rd_mux : dat_ff;
		end
	end

	// control and mask registers
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			arec_en_ff <= `PLG_CTRL_RST;
			mask_ff    <= `PLG_MASK_RST;
		end else begin
			if (wr_now && sel_ctrl) begin
				arec_en_ff <= WB_DAT_I[`PLG_CTRL_AREC_BIT];
			end
			if (wr_now && sel_mask) begin
				mask_ff <= WB_DAT_I[4:0];
			end
		end
	end

	// sticky status: a new event beats a write-one-to-clear
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			evt_ff <= `PLG_EVT_RST;
		end else begin
			evt_ff <= (evt_ff & ~evt_clr) | evt_set;
		end
	end

	// ***************************************************************
	// assertions
	// ***************************************************************
	therm_cut_a: assert property (                                // R11
		@(posedge CORE_CLK) disable iff (!RST_N)
		therm_s |-> !GATE_DRIVE_EN ##1 (state_ff == S_THERM))
		else $error("driver not cut on thermal shutdown");

	therm_hold_a: assert property (                               // R12
		@(posedge CORE_CLK) disable iff (!RST_N)
		(state_ff == S_THERM) |-> (SUPPLY_HOLD && LOW_POWER_OFF))
		else $error("supply not held in thermal shutdown");

	therm_exit_a: assert property (                               // R13
		@(posedge CORE_CLK) disable iff (!RST_N)
		(state_ff == S_THERM && !therm_s) |=> (state_ff == S_WAIT))
		else $error("no restart after cooling");

	tran_trip_a: assert property (                                // R2
		@(posedge CORE_CLK) disable iff (!RST_N)
		(switching && tran_done && !therm_s && !rel_s)
		|=> (state_ff == S_PROT || state_ff == S_AREC))
		else $error("transient expiry did not protect");

	tran_clear_a: assert property (                               // R15
		@(posedge CORE_CLK) disable iff (!RST_N)
		!tran_s |=> !tran_done)
		else $error("transient timer not cleared");

	fault_clear_a: assert property (                              // R14
		@(posedge CORE_CLK) disable iff (!RST_N)
		!lim_s |=> !flt_done)
		else $error("overload timer not cleared");

	latch_wait_a: assert property (                               // R7
		@(posedge CORE_CLK) disable iff (!RST_N)
		(state_ff == S_WAIT && !start_s) ##1 (state_ff == S_WAIT)
		|-> !hi_done && !lo_done)
		else $error("latch seen before ready");

	low_ignore_a: assert property (                               // R9
		@(posedge CORE_CLK) disable iff (!RST_N)
		(state_ff == S_SOFT) |-> !lo_done)
		else $error("low latch seen during soft-start");

	bias_ss_a: assert property (                                  // R10
		@(posedge CORE_CLK) disable iff (!RST_N)
		$rose(state_ff == S_RUN) |-> !SOFTSTART_BIAS_SEL && $past(SOFTSTART_BIAS_SEL))
		else $error("bias not reverted after soft-start");

	start_gate_a: assert property (                               // R8
		@(posedge CORE_CLK) disable iff (!RST_N)
		(state_ff == S_WAIT && start_s && hi_s && !therm_s)
		|=> !GATE_DRIVE_EN)
		else $error("switching began under high latch");

	latch_keep_a: assert property (                               // R6
		@(posedge CORE_CLK) disable iff (!RST_N)
		(state_ff == S_PROT && !rel_s && !therm_s) |=> (state_ff == S_PROT))
		else $error("latch released without reset");

	latch_off_a: assert property (                                // R4
		@(posedge CORE_CLK) disable iff (!RST_N)
		(switching && lo_done && !therm_s && !rel_s) |=> (state_ff == S_PROT) [*2])
		else $error("low latch did not latch off");
endmodule : plg_core

/* tb/plg_stage_model.sv */
/*
 * Far-side model: comparators and flyback stage that feed the sense inputs.
 * Assumes the bench sets load and pin levels just after a clock edge.
 */
`timescale 1ns/1ps

module plg_stage_model (
	input  wire logic                CORE_CLK,
	input  wire logic                GATE_DRIVE_EN,
	input  wire logic [1:0]          LOAD,
	input  wire plg_pkg::plg_sense_t PINS,
	output plg_pkg::plg_sense_t      SENSE
);
	import plg_pkg::*;

	// ********
	// comparators
	// ********
	// current sense only ramps while the switch is driven, so a stopped
	// stage cannot keep a timer alive by itself
	always_ff @(posedge CORE_CLK) begin
		SENSE <= {GATE_DRIVE_EN && (LOAD >= 2'h1), GATE_DRIVE_EN && (LOAD >= 2'h2), PINS[5:0]};
	end
endmodule : plg_stage_model

/* tb/protection_latch_logic_tb.sv */
/*
 * Self-checking bench of the protection sequencer: start-up gating,
 * latch window blanking, both timers, autorecovery, thermal shutdown
 * and interrupts, all observed through classic Wishbone and the pins.
 * Assumes plg_core with shortened counts and the stage model beside it.
 */
`timescale 1ns/1ps
`include "plg_cfg.svh"

module protection_latch_logic_tb;
	import plg_pkg::*;

	localparam int TRAN = 200;
	localparam int FLT  = 100;
	localparam int HI   = 20;
	localparam int LO   = 40;
	localparam int SS   = 50;
	localparam int AREC = 60;

	logic            core_clk = 1'b0;
	logic            rst_n    = 1'b0;
	logic            cyc      = 1'b0;
	logic            stb      = 1'b0;
	logic            we       = 1'b0;
	logic [7:0]      adr      = 8'h00;
	logic [3:0]      sel      = 4'h0;
	logic [31:0]     wdat     = 32'h0000_0000;
	logic [31:0]     rdat;
	logic [1:0]      load     = 2'h0;
	plg_sense_t      pins     = '0;
	plg_sense_t      sense;
	wire logic [31:0] dat_o;
	wire logic       ack, drive, bias, hold, lpo, irq;
	int              n_errors = 0;
	int              tests_run = 0;
	int              cyc_cnt  = 0;
	int              exp_irq  = 0;
	logic [7:0]      ofs [4]  = '{`PLG_CTRL_OFS, `PLG_IRQ_OFS, `PLG_MASK_OFS, 8'h10};

	plg_core #(.TRAN_CYC(TRAN), .FAULT_CYC(FLT), .HI_CYC(HI), .LO_CYC(LO), .SS_CYC(SS), .AREC_CYC(AREC)) DUT (
		.CORE_CLK           (core_clk),
		.RST_N              (rst_n),
		.SENSE              (sense),
		.WB_CYC_I           (cyc),
		.WB_STB_I           (stb),
		.WB_WE_I            (we),
		.WB_ADR_I           (adr),
		.WB_SEL_I           (sel),
		.WB_DAT_I           (wdat),
		.WB_DAT_O           (dat_o),
		.WB_ACK_O           (ack),
		.GATE_DRIVE_EN      (drive),
		.SOFTSTART_BIAS_SEL (bias),
		.SUPPLY_HOLD        (hold),
		.LOW_POWER_OFF      (lpo),
		.IRQ                (irq)
	);

	plg_stage_model stage (
		.CORE_CLK      (core_clk),
		.GATE_DRIVE_EN (drive),
		.LOAD          (load),
		.PINS          (pins),
		.SENSE         (sense)
	);

	// 250 MHz core clock
	always #2 core_clk = ~core_clk;

	// hang guard: the sequence needs well under 5000 cycles
	always @(posedge core_clk) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			n_errors++;
			wrap_up();
		end
	end

	// ********
	// helpers
	// ********
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc_n(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc_n

	// one classic cycle; ack and data are the values sampled at the edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		sel  <= 4'hF;
		@(posedge core_clk);
		// no limit of its own: a slave that never answers hits the hang guard
		while (ack !== 1'b1) begin
			@(posedge core_clk);
		end
		rdat = dat_o;
		cyc  <= 1'b0;
		stb  <= 1'b0;
		we   <= 1'b0;
		@(posedge core_clk);
	endtask : wb

	// poll the state field until it shows st or the budget runs out
	task automatic wait_st(input plg_state_t st, input int lim);
		int k;
		k = 0;
		wb(1'b0, `PLG_STAT_OFS, 32'h0000_0000);
		while (rdat[2:0] !== st && k < lim) begin
			wb(1'b0, `PLG_STAT_OFS, 32'h0000_0000);
			k += 3;
		end
		chk(32'(rdat[2:0]), 32'(st));
	endtask : wait_st

	task automatic irq_is(input int e);
		wb(1'b0, `PLG_IRQ_OFS, 32'h0000_0000);
		chk(rdat, 32'(e));
		chk(32'(irq), 32'(e != 0));
	endtask : irq_is

	// brown-out pulse, then a full start-up into run
	task automatic restart;
		pins.brown_out <= 1'b1;
		cyc_n(5);
		pins.brown_out <= 1'b0;
		wait_st(S_RUN, 300);
	endtask : restart

	// ********
	// sequence
	// ********
	initial begin
		void'($urandom(23003));
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		chk(32'({drive, bias, hold, lpo, irq}), 32'h0000_0000);
		foreach (ofs[i]) begin
			wb(1'b0, ofs[i], 32'h0000_0000);
			chk(rdat, 32'h0000_0000);
		end
		wb(1'b1, `PLG_MASK_OFS, 32'h0000_001F);
		wb(1'b0, `PLG_MASK_OFS, 32'h0000_0000);
		chk(rdat, 32'h0000_001F);
		// both latch levels present before the supply is ready
		pins.latch_high <= 1'b1;
		pins.latch_low  <= 1'b1;
		cyc_n(30);
		wait_st(S_WAIT, 3);
		irq_is(0);
		pins.supply_start_level <= 1'b1;
		wait_st(S_PROT, HI + 20);
		chk(32'(drive), 32'h0000_0000);
		exp_irq = 32'h0000_0004;
		irq_is(exp_irq);
		// low latch stays high through soft-start
		pins.latch_high <= 1'b0;
		restart_low: begin
			pins.brown_out <= 1'b1;
			cyc_n(5);
			pins.brown_out <= 1'b0;
		end
		wait_st(S_SOFT, 30);
		chk(32'({drive, bias}), 32'h0000_0003);
		wait_st(S_RUN, SS + 20);
		chk(32'(bias), 32'h0000_0000);
		wait_st(S_PROT, LO + 20);
		cyc_n(100);
		wait_st(S_PROT, 3);
		exp_irq |= 32'h0000_0008;
		irq_is(exp_irq);
		pins.latch_low    <= 1'b0;
		pins.supply_reset <= 1'b1;
		cyc_n(5);
		pins.supply_reset <= 1'b0;
		wait_st(S_RUN, 300);
		// short excursions of random length on both thresholds
		for (int i = 0; i < 4; i++) begin
			pins.latch_high <= 1'b1;
			cyc_n($urandom_range(HI - 5, 1));
			pins.latch_high <= 1'b0;
			pins.latch_low  <= 1'b1;
			cyc_n($urandom_range(LO - 5, 1));
			pins.latch_low  <= 1'b0;
			cyc_n(6);
			chk(32'(drive), 32'h0000_0001);
		end
		pins.latch_high <= 1'b1;
		cyc_n(HI - 5);
		wait_st(S_RUN, 3);
		wait_st(S_PROT, 20);
		chk(32'(drive), 32'h0000_0000);
		pins.latch_high <= 1'b0;
		// blanked level keeps re-setting its event until the sync chain empties
		cyc_n(6);
		wb(1'b1, `PLG_IRQ_OFS, 32'h0000_001F);
		exp_irq = 0;
		irq_is(exp_irq);
		// transient timer: interrupted bursts, then a full one
		restart();
		for (int i = 0; i < 3; i++) begin
			load <= 2'h1;
			cyc_n(TRAN - 50);
			load <= 2'h0;
			cyc_n(10);
		end
		wait_st(S_RUN, 3);
		load <= 2'h1;
		cyc_n(TRAN - 10);
		wait_st(S_RUN, 3);
		wait_st(S_PROT, 40);
		load <= 2'h0;
		irq_is(32'h0000_0001);
		wb(1'b1, `PLG_MASK_OFS, 32'h0000_001E);
		chk(32'(irq), 32'h0000_0000);
		wb(1'b1, `PLG_MASK_OFS, 32'h0000_001F);
		wb(1'b1, `PLG_IRQ_OFS, 32'h0000_0001);
		irq_is(0);
		// overload timer: interrupted, then after a transient spell
		restart();
		for (int i = 0; i < 3; i++) begin
			load <= 2'h2;
			cyc_n(FLT - 20);
			load <= 2'h0;
			cyc_n(10);
		end
		wait_st(S_RUN, 3);
		load <= 2'h1;
		cyc_n(50);
		load <= 2'h2;
		cyc_n(FLT - 10);
		wait_st(S_RUN, 3);
		wait_st(S_PROT, 40);
		load <= 2'h0;
		irq_is(32'h0000_0002);
		// autorecovery control register bit
		wb(1'b1, `PLG_CTRL_OFS, 32'h0000_0001);
		restart();
		load <= 2'h2;
		wait_st(S_AREC, FLT + 40);
		load <= 2'h0;
		chk(32'(drive), 32'h0000_0000);
		wait_st(S_RUN, AREC + SS + 60);
		wb(1'b1, `PLG_CTRL_OFS, 32'h0000_0000);
		wb(1'b1, `PLG_IRQ_OFS, 32'h0000_001F);
		// thermal shutdown, release ignored while hot
		pins.thermal_shutdown <= 1'b1;
		cyc_n(5);
		chk(32'(drive), 32'h0000_0000);
		wait_st(S_THERM, 20);
		chk(32'({hold, lpo}), 32'h0000_0003);
		pins.brown_out <= 1'b1;
		cyc_n(5);
		pins.brown_out <= 1'b0;
		cyc_n(10);
		wait_st(S_THERM, 3);
		irq_is(32'h0000_0010);
		pins.thermal_shutdown <= 1'b0;
		wait_st(S_RUN, 300);
		chk(32'({hold, lpo, drive}), 32'h0000_0001);
		wrap_up();
	end
endmodule : protection_latch_logic_tb
